/* File: common/dhmb_pkg.sv */
// Shared constants of the DSP and host mailbox block.
// Assumes a DSP register port with 16-bit words and an 8-bit host byte port.
package dhmb_pkg;
  localparam int unsigned DHMB_WORDS = 16;
  localparam int unsigned DHMB_CNT_W = 4;
  // DSP side word addresses.
  localparam logic [15:0] DSP_H2D_BASE = 16'hd100;
  localparam logic [15:0] DSP_D2H_BASE = 16'hd120;
  localparam logic [15:0] DSP_HCMD = 16'hd140;
  localparam logic [15:0] DSP_HFULL = 16'hd141;
  localparam logic [15:0] DSP_MGEN_LO = 16'hd142;
  localparam logic [15:0] DSP_MGEN_HI = 16'hd143;
  localparam logic [15:0] DSP_MGEN = 16'hd144;
  localparam logic [15:0] DSP_TX_CNT = 16'hd150;
  localparam logic [15:0] DSP_DCMD = 16'hd160;
  localparam logic [15:0] DSP_DFULL = 16'hd161;
  localparam logic [15:0] DSP_DGEN_LO = 16'hd162;
  localparam logic [15:0] DSP_DGEN_HI = 16'hd163;
  localparam logic [15:0] DSP_DGEN = 16'hd164;
  localparam logic [15:0] DSP_RX_CNT = 16'hd170;
  // Host side byte addresses.
  localparam logic [7:0] HOST_H2D_BASE = 8'h00;
  localparam logic [7:0] HOST_D2H_BASE = 8'h20;
  localparam logic [7:0] HOST_HCMD = 8'h40;
  localparam logic [7:0] HOST_HFULL = 8'h41;
  localparam logic [7:0] HOST_MGEN_LO = 8'h42;
  localparam logic [7:0] HOST_MGEN_HI = 8'h43;
  localparam logic [7:0] HOST_DCMD = 8'h60;
  localparam logic [7:0] HOST_DFULL = 8'h61;
  localparam logic [7:0] HOST_DGEN_LO = 8'h62;
  localparam logic [7:0] HOST_DGEN_HI = 8'h63;
  // Field positions and reset values.
  localparam int unsigned BUSY_BIT = 15;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic BUSY_RST = 1'b0;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] DMA_WORD_BASE = 4'h8;
  typedef enum logic [1:0] {
    DHMB_IDLE = 2'b00,
    DHMB_MOVE = 2'b01
  } dhmb_dma_state_t;
endpackage

/* File: common/dhmb_dma_if.sv */
// Control link between the mailbox top and one DMA byte engine.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
interface dhmb_dma_if;
  logic start;
  logic [3:0] count;
  logic step;
  logic busy;
  logic [3:0] idx;
  logic done;
  modport ctrl (output start, output count, output step, input busy, input idx, input done);
  modport eng (input start, input count, input step, output busy, output idx, output done);
endinterface

/* File: rtl/dhmb_busy_flag.sv */
// Mailbox busy flag: set by the sender's command write, cleared by the receiver.
// Assumes set and clear requests are one-cycle pulses on core_clk.
`timescale 1ns/10ps
module dhmb_busy_flag
  import dhmb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic set_req,
  input wire logic clr_req,
  output logic full_ff
);
  // A set while the flag is free beats a clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      full_ff <= BUSY_RST;
    end else if (set_req && !full_ff) begin
      full_ff <= 1'b1;
    end else if (clr_req) begin
      full_ff <= 1'b0;
    end
  end

  chk_flag_set: assert property (@(posedge core_clk) disable iff (srst)
    set_req && !full_ff |=> full_ff) else $error("Busy flag not set by command write.");
  chk_flag_clear: assert property (@(posedge core_clk) disable iff (srst)
    clr_req && full_ff |=> !full_ff) else $error("Busy flag not cleared by receiver write.");
  chk_flag_stable: assert property (@(posedge core_clk) disable iff (srst)
    !set_req && !clr_req |=> $stable(full_ff)) else $error("Busy flag changed without cause.");
endmodule

/* File: rtl/dhmb_dma_engine.sv */
// Byte sequencer for one DMA mailbox direction.
// Assumes step is a one-cycle pulse per byte moved by the outside DMA.
`timescale 1ns/10ps
module dhmb_dma_engine
  import dhmb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  dhmb_dma_if.eng dma
);
  dhmb_dma_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [3:0] idx_ff;
  logic done_ff;

  // Bytes are walked upward from byte zero; a count of zero starts nothing.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= DHMB_IDLE;
      cnt_ff <= CNT_RST;
      idx_ff <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        DHMB_IDLE: begin
          if (dma.start && dma.count != 4'h0) begin
            state_ff <= DHMB_MOVE;
            cnt_ff <= dma.count;
            idx_ff <= 4'h0;
          end
        end
        DHMB_MOVE: begin
          if (dma.step) begin
            if (idx_ff == cnt_ff - 4'h1) begin
              state_ff <= DHMB_IDLE;
              done_ff <= 1'b1;
            end else begin
              idx_ff <= idx_ff + 4'h1;
            end
          end
        end
        default: begin
          state_ff <= DHMB_IDLE;
        end
      endcase
    end
  end

  assign dma.busy = (state_ff == DHMB_MOVE);
  assign dma.idx = idx_ff;
  assign dma.done = done_ff;

  chk_start_first: assert property (@(posedge core_clk) disable iff (srst)
    !dma.busy && dma.start && dma.count != 4'h0 |=> dma.busy && dma.idx == 4'h0)
    else $error("Transfer did not start at byte zero.");
  chk_step_up: assert property (@(posedge core_clk) disable iff (srst)
    dma.busy && dma.step && (dma.idx != cnt_ff - 4'h1) |=> dma.busy && dma.idx == $past(dma.idx) + 4'h1)
    else $error("Byte index did not advance by one.");
  chk_last_done: assert property (@(posedge core_clk) disable iff (srst)
    dma.busy && dma.step && (dma.idx == cnt_ff - 4'h1) |=> dma.done && !dma.busy)
    else $error("Transfer did not end after the last byte.");
endmodule

/* File: rtl/dhmb_mailbox.sv */
// Two-way mailbox between the embedded DSP and the external host processor.
// Assumes DSP strobes on core_clk, host strobes and DMA pins asynchronous.
// Function
// - DSP writes an 8-bit command byte that the host reads.
// - Each accepted DSP command write sets the DSP mailbox busy flag.
// - A host write to the DSP busy register clears that flag.
// - DSP command writes are ignored while the DSP busy flag is set.
// - DSP writes a 16-bit generic word; host reads its two bytes.
// - Sixteen DSP-to-host words, written by DSP, read bytewise by host.
// - Sixteen host-to-DSP words, written bytewise by host, read by DSP.
// - Upper eight host-to-DSP words are the DMA transmit mailbox.
// - Upper eight DSP-to-host words are the DMA receive mailbox.
// - Writing the transmit count starts a transfer of that many bytes.
// - Writing the receive count starts a transfer of that many bytes.
// - Count registers hold their written value during the transfer.
// - Each accepted host command write sets the host mailbox busy flag.
// - A DSP write to the host busy register clears that flag.
`timescale 1ns/10ps
module dhmb_mailbox
  import dhmb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] dsp_addr,
  input wire logic dsp_wr,
  input wire logic dsp_rd,
  input wire logic [15:0] dsp_wdata,
  output logic [15:0] dsp_rdata,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic dma_tx_req,
  input wire logic dma_tx_ack,
  input wire logic [7:0] dma_tx_byte,
  output logic dma_rx_req,
  input wire logic dma_rx_ack,
  output logic [7:0] dma_rx_byte,
  output logic dsp_mbox_full,
  output logic host_mbox_full
);
  localparam int unsigned SYNC_W = 28;

  // Returns the high or low byte of a word.
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // Replaces the high or low byte of a word.
  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi, input logic [7:0] b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic hwr_d_ff;
  logic txack_d_ff;
  logic rxack_d_ff;
  logic [7:0] h_addr;
  logic [7:0] h_data;
  logic h_wr;
  logic h_rd;
  logic tx_ack;
  logic [7:0] tx_byte;
  logic rx_ack;
  logic h_wr_p;
  logic [7:0] cmd_ff;
  logic [7:0] hcmd_ff;
  logic [15:0] dgen_ff;
  logic [15:0] mgen_ff;
  logic [3:0] tx_cnt_ff;
  logic [3:0] rx_cnt_ff;
  logic [15:0] h2d_mem [DHMB_WORDS];
  logic [15:0] d2h_mem [DHMB_WORDS];
  logic dsp_full;
  logic host_full;
  logic dsp_cmd_wr;
  logic host_cmd_wr;
  logic dsp_clr;
  logic host_clr;
  logic tx_wr;
  logic rx_wr;
  logic [15:0] dsp_rd_val;
  logic [7:0] host_rd_val;
  logic [15:0] bz_word;

  dhmb_dma_if tx_if ();
  dhmb_dma_if rx_if ();

  // Two-stage synchroniser for every host and DMA pin.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {host_addr, host_data_in, host_wr, host_rd, dma_tx_ack, dma_tx_byte, dma_rx_ack};
      sync2_ff <= sync1_ff;
    end
  end

  assign {h_addr, h_data, h_wr, h_rd, tx_ack, tx_byte, rx_ack} = sync2_ff;

  // Delayed copies of the synchronised strobes for rising-edge pulses.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hwr_d_ff <= 1'b0;
      txack_d_ff <= 1'b0;
      rxack_d_ff <= 1'b0;
    end else begin
      hwr_d_ff <= h_wr;
      txack_d_ff <= tx_ack;
      rxack_d_ff <= rx_ack;
    end
  end

  assign h_wr_p = h_wr && !hwr_d_ff;

  // Write strobes that touch flags and counters.
  assign dsp_cmd_wr = dsp_wr && (dsp_addr == DSP_DCMD);
  assign host_cmd_wr = h_wr_p && (h_addr == HOST_HCMD);
  assign dsp_clr = h_wr_p && (h_addr == HOST_DFULL);
  assign host_clr = dsp_wr && (dsp_addr == DSP_HFULL);
  assign tx_wr = dsp_wr && (dsp_addr == DSP_TX_CNT);
  assign rx_wr = dsp_wr && (dsp_addr == DSP_RX_CNT);

  dhmb_busy_flag u_dsp_flag (
    .core_clk(core_clk),
    .srst(srst),
    .set_req(dsp_cmd_wr),
    .clr_req(dsp_clr),
    .full_ff(dsp_full)
  );

  dhmb_busy_flag u_host_flag (
    .core_clk(core_clk),
    .srst(srst),
    .set_req(host_cmd_wr),
    .clr_req(host_clr),
    .full_ff(host_full)
  );

  // Command bytes are only taken while their mailbox is free.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_ff <= CMD_RST;
      hcmd_ff <= CMD_RST;
    end else begin
      if (dsp_cmd_wr && !dsp_full) begin
        cmd_ff <= dsp_wdata[7:0];
      end
      if (host_cmd_wr && !host_full) begin
        hcmd_ff <= h_data;
      end
    end
  end

  // Generic words; both keep their contents over reset.
  always_ff @(posedge core_clk) begin
    if (dsp_wr && dsp_addr == DSP_DGEN) begin
      dgen_ff <= dsp_wdata;
    end else if (dsp_wr && dsp_addr == DSP_DGEN_LO) begin
      dgen_ff <= put_byte(dgen_ff, 1'b0, dsp_wdata[7:0]);
    end else if (dsp_wr && dsp_addr == DSP_DGEN_HI) begin
      dgen_ff <= put_byte(dgen_ff, 1'b1, dsp_wdata[7:0]);
    end
    if (h_wr_p && h_addr == HOST_MGEN_LO) begin
      mgen_ff <= put_byte(mgen_ff, 1'b0, h_data);
    end else if (h_wr_p && h_addr == HOST_MGEN_HI) begin
      mgen_ff <= put_byte(mgen_ff, 1'b1, h_data);
    end
  end

  // Byte counters accept a write only while their transfer is idle.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_cnt_ff <= CNT_RST;
      rx_cnt_ff <= CNT_RST;
    end else begin
      if (tx_wr && !tx_if.busy) begin
        tx_cnt_ff <= dsp_wdata[3:0];
      end
      if (rx_wr && !rx_if.busy) begin
        rx_cnt_ff <= dsp_wdata[3:0];
      end
    end
  end

  assign tx_if.start = tx_wr && !tx_if.busy;
  assign tx_if.count = dsp_wdata[3:0];
  assign tx_if.step = tx_if.busy && tx_ack && !txack_d_ff;
  assign rx_if.start = rx_wr && !rx_if.busy;
  assign rx_if.count = dsp_wdata[3:0];
  assign rx_if.step = rx_if.busy && rx_ack && !rxack_d_ff;

  dhmb_dma_engine u_tx_eng (
    .core_clk(core_clk),
    .srst(srst),
    .dma(tx_if)
  );

  dhmb_dma_engine u_rx_eng (
    .core_clk(core_clk),
    .srst(srst),
    .dma(rx_if)
  );

  // Host-to-DSP words: host byte writes, then DMA transmit bytes, which win.
  always_ff @(posedge core_clk) begin
    if (h_wr_p && h_addr[7:5] == HOST_H2D_BASE[7:5]) begin
      h2d_mem[h_addr[4:1]] <= put_byte(h2d_mem[h_addr[4:1]], h_addr[0], h_data);
    end
    if (tx_if.step) begin
      h2d_mem[{1'b1, tx_if.idx[3:1]}] <= put_byte(h2d_mem[{1'b1, tx_if.idx[3:1]}], tx_if.idx[0], tx_byte);
    end
  end

  // DSP-to-host words are written whole by the DSP.
  always_ff @(posedge core_clk) begin
    if (dsp_wr && dsp_addr[15:4] == DSP_D2H_BASE[15:4]) begin
      d2h_mem[dsp_addr[3:0]] <= dsp_wdata;
    end
  end

  // DSP read decode.
  always_comb begin
    dsp_rd_val = 16'h0000;
    if (dsp_addr[15:4] == DSP_H2D_BASE[15:4]) begin
      dsp_rd_val = h2d_mem[dsp_addr[3:0]];
    end else if (dsp_addr[15:4] == DSP_D2H_BASE[15:4]) begin
      dsp_rd_val = d2h_mem[dsp_addr[3:0]];
    end else if (dsp_addr == DSP_HCMD) begin
      dsp_rd_val = {8'h00, hcmd_ff};
    end else if (dsp_addr == DSP_HFULL) begin
      dsp_rd_val = {host_full, 15'h0000};
    end else if (dsp_addr == DSP_MGEN) begin
      dsp_rd_val = mgen_ff;
    end else if (dsp_addr == DSP_MGEN_LO) begin
      dsp_rd_val = {8'h00, pick_byte(mgen_ff, 1'b0)};
    end else if (dsp_addr == DSP_MGEN_HI) begin
      dsp_rd_val = {8'h00, pick_byte(mgen_ff, 1'b1)};
    end else if (dsp_addr == DSP_DFULL) begin
      dsp_rd_val = {dsp_full, 15'h0000};
    end else if (dsp_addr == DSP_TX_CNT) begin
      dsp_rd_val = {12'h000, tx_cnt_ff};
    end else if (dsp_addr == DSP_RX_CNT) begin
      dsp_rd_val = {12'h000, rx_cnt_ff};
    end
  end

  // Host read decode.
  always_comb begin
    bz_word = 16'h0000;
    host_rd_val = 8'h00;
    if (h_addr[7:5] == HOST_D2H_BASE[7:5]) begin
      host_rd_val = pick_byte(d2h_mem[h_addr[4:1]], h_addr[0]);
    end else if (h_addr == HOST_DCMD) begin
      host_rd_val = cmd_ff;
    end else if (h_addr == HOST_DFULL) begin
      bz_word[BUSY_BIT] = dsp_full;
      host_rd_val = pick_byte(bz_word, 1'b1);
    end else if (h_addr == HOST_HFULL) begin
      bz_word[BUSY_BIT] = host_full;
      host_rd_val = pick_byte(bz_word, 1'b1);
    end else if (h_addr == HOST_DGEN_LO) begin
      host_rd_val = pick_byte(dgen_ff, 1'b0);
    end else if (h_addr == HOST_DGEN_HI) begin
      host_rd_val = pick_byte(dgen_ff, 1'b1);
    end
  end

  // Registered read data and the DMA receive byte.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dsp_rdata <= 16'h0000;
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
      dma_rx_byte <= 8'h00;
    end else begin
      if (dsp_rd) begin
        dsp_rdata <= dsp_rd_val;
      end
      host_data_out <= host_rd_val;
      host_data_oe <= h_rd;
      dma_rx_byte <= pick_byte(d2h_mem[{1'b1, rx_if.idx[3:1]}], rx_if.idx[0]);
    end
  end

  assign dma_tx_req = tx_if.busy;
  assign dma_rx_req = rx_if.busy;
  assign dsp_mbox_full = dsp_full;
  assign host_mbox_full = host_full;

  chk_cmd_refused: assert property (@(posedge core_clk) disable iff (srst)
    dsp_cmd_wr && dsp_full |=> $stable(cmd_ff)) else $error("Command taken while mailbox busy.");
  chk_cmd_taken: assert property (@(posedge core_clk) disable iff (srst)
    dsp_cmd_wr && !dsp_full |=> dsp_full && cmd_ff == $past(dsp_wdata[7:0]))
    else $error("Command write not stored with busy set.");
  chk_tx_cnt_hold: assert property (@(posedge core_clk) disable iff (srst)
    tx_if.busy |=> $stable(tx_cnt_ff)) else $error("Transmit count changed during transfer.");
  chk_rx_cnt_hold: assert property (@(posedge core_clk) disable iff (srst)
    rx_if.busy |=> $stable(rx_cnt_ff)) else $error("Receive count changed during transfer.");
  chk_tx_byte_store: assert property (@(posedge core_clk) disable iff (srst)
    tx_if.step |=> pick_byte(h2d_mem[{1'b1, $past(tx_if.idx[3:1])}], $past(tx_if.idx[0])) == $past(tx_byte))
    else $error("Transmit byte not stored in mailbox.");
endmodule

/* File: test/dhmb_host_model.sv */
// Partner model of the external microprocessor on the byte-wide host bus.
// Assumes the bench calls its tasks just after a core_clk rising edge.
`timescale 1ns/10ps
module dhmb_host_model (
  input wire logic core_clk,
  output logic [7:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_data_in
);
  localparam time DLY = 10ns;
  // Strobes idle low; released data lines show a stale inverted pattern.
  initial begin
    host_addr = 8'h7f;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_data_in = 8'h5a;
  end
  // Byte write: address and data settle three cycles before the strobe and outlast it.
  task automatic hwrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #DLY;
    host_addr = a;
    host_data_in = d;
    repeat (3) @(posedge core_clk);
    #DLY host_wr = 1'b1;
    repeat (3) @(posedge core_clk);
    #DLY host_wr = 1'b0;
    @(posedge core_clk) #DLY;
    host_data_in = ~d;
    host_addr = ~a;
    repeat (3) @(posedge core_clk);
    #DLY;
  endtask
  // Opens a read of one byte; the strobe stays up until hclose.
  task automatic hopen(input logic [7:0] a);
    @(posedge core_clk) #DLY;
    host_addr = a;
    host_rd = 1'b1;
  endtask
  // Ends a read and moves the address away so stale bytes cannot pass.
  task automatic hclose();
    host_rd = 1'b0;
    host_addr = ~host_addr;
    repeat (2) @(posedge core_clk);
    #DLY;
  endtask
endmodule

/* File: test/dhmb_mailbox_tb.sv */
// Self-checking bench of the DSP and host mailbox.
// Assumes the host model partner and the mailbox package are compiled first.
`timescale 1ns/10ps
module dhmb_mailbox_tb import dhmb_pkg::*;;
  localparam time DLY = 10ns;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] dsp_addr = 16'h0;
  logic dsp_wr = 1'b0;
  logic dsp_rd = 1'b0;
  logic [15:0] dsp_wdata = 16'h0;
  logic [15:0] dsp_rdata;
  logic [7:0] host_addr, host_data_in, host_data_out;
  logic host_wr, host_rd, host_data_oe, dma_tx_req, dma_rx_req;
  logic dma_tx_ack = 1'b0;
  logic dma_rx_ack = 1'b0;
  logic [7:0] dma_tx_byte = 8'h0;
  logic [7:0] dma_rx_byte, c1, c2;
  logic dsp_mbox_full, host_mbox_full;
  logic look_v = 1'b0;
  logic [1:0] look_k = 2'd0;
  logic [15:0] exp_q[$];
  string name_q[$];
  int err_total = 0;
  int total_checks = 0;
  logic [15:0] w[16];
  logic [15:0] m[16];
  logic [15:0] g, e;
  logic [7:0] b[3];
  // Clock of 100 ns period.
  always #50 core_clk = ~core_clk;
  dhmb_host_model i_host (.core_clk(core_clk), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_data_in(host_data_in));
  dhmb_mailbox i_dhmb_mailbox (.core_clk(core_clk), .srst(srst), .dsp_addr(dsp_addr), .dsp_wr(dsp_wr),
    .dsp_rd(dsp_rd), .dsp_wdata(dsp_wdata), .dsp_rdata(dsp_rdata), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .dma_tx_req(dma_tx_req), .dma_tx_ack(dma_tx_ack),
    .dma_tx_byte(dma_tx_byte), .dma_rx_req(dma_rx_req), .dma_rx_ack(dma_rx_ack),
    .dma_rx_byte(dma_rx_byte), .dsp_mbox_full(dsp_mbox_full), .host_mbox_full(host_mbox_full));
  // Counts every comparison and reports a mismatch at once.
  task automatic tally(input string nm, input logic [15:0] ex, input logic [15:0] got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Compares the registered DSP read data.
  task automatic cmp_dsp(input string nm, input logic [15:0] ex);
    tally(nm, ex, dsp_rdata);
  endtask
  // Compares the host data byte together with its output enable.
  task automatic cmp_host(input string nm, input logic [15:0] ex);
    tally(nm, ex, {7'h0, host_data_oe, host_data_out});
  endtask
  // Compares the byte offered to the receive DMA.
  task automatic cmp_rx(input string nm, input logic [15:0] ex);
    tally(nm, ex, {8'h0, dma_rx_byte});
  endtask
  // Compares both busy flags and both DMA requests.
  task automatic cmp_flags(input string nm, input logic [15:0] ex);
    tally(nm, ex, {12'h0, host_mbox_full, dsp_mbox_full, dma_rx_req, dma_tx_req});
  endtask
  // Notes an expected result and flags the watcher to compare at the next edge.
  task automatic note(input logic [1:0] k, input logic [15:0] ex, input string nm);
    exp_q.push_back(ex);
    name_q.push_back(nm);
    look_k = k;
    look_v = 1'b1;
    @(posedge core_clk) #DLY;
    look_v = 1'b0;
    @(posedge core_clk) #DLY;
  endtask
  // Watcher takes the oldest note whenever a result is flagged; mid-cycle, where outputs are settled.
  always @(negedge core_clk) begin
    if (look_v) begin
      case (look_k)
        2'd0: cmp_dsp(name_q.pop_front(), exp_q.pop_front());
        2'd1: cmp_host(name_q.pop_front(), exp_q.pop_front());
        2'd2: cmp_rx(name_q.pop_front(), exp_q.pop_front());
        default: cmp_flags(name_q.pop_front(), exp_q.pop_front());
      endcase
    end
  end
  // One DSP write strobe; an edge passes before the next one.
  task automatic dsp_write(input logic [15:0] a, input logic [15:0] d);
    dsp_addr = a;
    dsp_wdata = d;
    dsp_wr = 1'b1;
    @(posedge core_clk) #DLY;
    dsp_wr = 1'b0;
    @(posedge core_clk) #DLY;
  endtask
  // One DSP read strobe; read data is compared half a cycle after the edge that samples it.
  task automatic dsp_read(input logic [15:0] a, input logic [15:0] ex, input string nm);
    dsp_addr = a;
    dsp_rd = 1'b1;
    @(posedge core_clk) #DLY;
    dsp_rd = 1'b0;
    note(2'd0, ex, nm);
  endtask
  // Host byte read, compared once the pin synchronisers have settled.
  task automatic host_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
    i_host.hopen(a);
    repeat (4) @(posedge core_clk);
    #DLY;
    note(2'd1, {7'h0, 1'b1, ex}, nm);
    i_host.hclose();
  endtask
  // One transmit DMA byte; the byte is stable three cycles before the acknowledge and one cycle after it.
  task automatic dma_send(input logic [7:0] d);
    dma_tx_byte = d;
    repeat (3) @(posedge core_clk);
    #DLY dma_tx_ack = 1'b1;
    repeat (3) @(posedge core_clk);
    #DLY dma_tx_ack = 1'b0;
    @(posedge core_clk) #DLY;
    dma_tx_byte = ~d;
    repeat (3) @(posedge core_clk);
    #DLY;
  endtask
  // Ends the run with the counts and the verdict.
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #1ms;
    err_total++;
    $display("timeout");
    close_out();
  end
  // Main sequence.
  initial begin
    void'($urandom(26));
    repeat (2) @(posedge core_clk);
    #DLY srst = 1'b0;
    repeat (3) @(posedge core_clk);
    #DLY;
    dsp_read(DSP_TX_CNT, 16'h0000, "tx count");
    dsp_read(DSP_RX_CNT, 16'h0000, "rx count");
    dsp_read(DSP_DFULL, 16'h0000, "dsp busy");
    dsp_read(DSP_HFULL, 16'h0000, "host busy");
    dsp_read(16'hd1ff, 16'h0000, "dsp unmapped");
    host_chk(HOST_DCMD, 8'h00, "dsp cmd");
    host_chk(8'h7f, 8'h00, "host unmapped");
    note(2'd3, 16'h0000, "flags");
    $display("test reset done");
    c1 = 8'($urandom);
    c2 = ~c1;
    dsp_write(DSP_DCMD, {8'h0, c1});
    note(2'd3, 16'h0004, "flags");
    dsp_read(DSP_DFULL, 16'h8000, "dsp busy");
    host_chk(HOST_DFULL, 8'h80, "dsp busy host");
    dsp_write(DSP_DCMD, {8'h0, c2});
    host_chk(HOST_DCMD, c1, "dsp cmd");
    i_host.hwrite(HOST_DFULL, 8'h00);
    dsp_read(DSP_DFULL, 16'h0000, "dsp busy");
    dsp_write(DSP_DCMD, {8'h0, c2});
    host_chk(HOST_DCMD, c2, "dsp cmd");
    i_host.hwrite(HOST_DFULL, 8'h5a);
    $display("test dsp command done");
    i_host.hwrite(HOST_HCMD, c1);
    note(2'd3, 16'h0008, "flags");
    i_host.hwrite(HOST_HCMD, c2);
    dsp_read(DSP_HCMD, {8'h0, c1}, "host cmd");
    host_chk(HOST_HFULL, 8'h80, "host busy");
    dsp_write(DSP_HFULL, 16'h1234);
    dsp_read(DSP_HFULL, 16'h0000, "host busy");
    note(2'd3, 16'h0000, "flags");
    $display("test host command done");
    g = 16'($urandom);
    dsp_write(DSP_DGEN, g);
    host_chk(HOST_DGEN_LO, g[7:0], "gen low");
    dsp_write(DSP_DGEN_HI, {8'h0, ~g[15:8]});
    host_chk(HOST_DGEN_HI, ~g[15:8], "gen high");
    host_chk(HOST_DGEN_LO, g[7:0], "gen low");
    dsp_write(DSP_DGEN_LO, {8'h0, c1});
    host_chk(HOST_DGEN_LO, c1, "gen low");
    host_chk(HOST_DGEN_HI, ~g[15:8], "gen high");
    i_host.hwrite(HOST_MGEN_LO, c1);
    i_host.hwrite(HOST_MGEN_HI, c2);
    dsp_read(DSP_MGEN, {c2, c1}, "host gen");
    dsp_read(DSP_MGEN_HI, {8'h0, c2}, "host gen high");
    dsp_read(DSP_MGEN_LO, {8'h0, c1}, "host gen low");
    $display("test generic done");
    for (int n = 0; n < 16; n++) begin
      w[n] = 16'($urandom);
      dsp_write(DSP_D2H_BASE + 16'(n), w[n]);
    end
    for (int n = 0; n < 16; n++) begin
      host_chk(HOST_D2H_BASE + 8'(2 * n), w[n][7:0], "out low");
      host_chk(HOST_D2H_BASE + 8'(2 * n + 1), w[n][15:8], "out high");
    end
    for (int n = 0; n < 16; n++) begin
      m[n] = 16'($urandom);
      i_host.hwrite(HOST_H2D_BASE + 8'(2 * n), m[n][7:0]);
      i_host.hwrite(HOST_H2D_BASE + 8'(2 * n + 1), m[n][15:8]);
      dsp_read(DSP_H2D_BASE + 16'(n), m[n], "in word");
    end
    $display("test data words done");
    dsp_write(DSP_TX_CNT, 16'h0000);
    note(2'd3, 16'h0000, "flags");
    dsp_write(DSP_TX_CNT, 16'h0003);
    note(2'd3, 16'h0001, "flags");
    dsp_write(DSP_TX_CNT, 16'h0005);
    dsp_read(DSP_TX_CNT, 16'h0003, "tx count");
    for (int k = 0; k < 3; k++) begin
      b[k] = 8'($urandom);
      dma_send(b[k]);
    end
    repeat (5) @(posedge core_clk);
    #DLY;
    note(2'd3, 16'h0000, "flags");
    dma_send(8'hff);
    dsp_read(DSP_H2D_BASE + 16'h8, {b[1], b[0]}, "tx word");
    dsp_read(DSP_H2D_BASE + 16'h9, {m[9][15:8], b[2]}, "tx word");
    dsp_read(DSP_TX_CNT, 16'h0003, "tx count");
    $display("test dma transmit done");
    dsp_write(DSP_RX_CNT, 16'h000f);
    note(2'd3, 16'h0002, "flags");
    dsp_write(DSP_RX_CNT, 16'h0002);
    for (int k = 0; k < 15; k++) begin
      e = w[8 + k / 2];
      repeat (3) @(posedge core_clk);
      #DLY;
      note(2'd2, {8'h0, k[0] ? e[15:8] : e[7:0]}, "rx byte");
      dma_rx_ack = 1'b1;
      repeat (3) @(posedge core_clk);
      #DLY dma_rx_ack = 1'b0;
      if (k == 7) begin
        dsp_read(DSP_RX_CNT, 16'h000f, "rx count");
      end
    end
    repeat (5) @(posedge core_clk);
    #DLY;
    note(2'd3, 16'h0000, "flags");
    $display("test dma receive done");
    close_out();
  end
endmodule
